//--- src/regulator_fault_supervisor.sv
// Fault supervisor: debounced fault inputs, regulator enables, flags, outputs.
// Assumes pin inputs are asynchronous and an Avalon-MM master on clk.
`timescale 1ns/100ps
`default_nettype none
`include "fault_sup_cfg.svh"

module regulator_fault_supervisor #(
    parameter logic [16:0] SC_CYC = `CYC_SC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic en_pin,
    input wire logic supply_uv_pin,
    input wire logic overvoltage_pin,
    input wire logic thermal_sd_pin,
    input wire logic thermal_warn_pin,
    input wire logic [3:0] output_below_pin,
    input wire logic [3:0] current_limit_detect,
    input wire logic [3:0] output_inreg_pin,
    output logic [3:0] reg_enable,
    output logic [3:0] discharge_on,
    output logic irq_n_pin,
    output logic power_good_pin,
    output fault_sup_pkg::mode_t mode,
    output logic general_output_one_o,
    output logic general_output_one_oe_n,
    output logic general_output_two_o,
    output logic general_output_two_oe_n,
    input wire logic general_output_two_i,
    output logic external_sync_clock_in
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [11:0] lim(input int idx, input logic rise);
        logic [11:0] r;
        r = `CYC_FLT;
        if (idx == `F_EN)
            r = `CYC_EN;
        else if (idx == `F_UV)
            r = rise ? `CYC_NOW : `CYC_EN;
        else if (idx == `F_OV)
            r = rise ? `CYC_OVR : `CYC_OVF;
        else if (idx >= `F_PG)
            r = `CYC_PG;
        return r;
    endfunction : lim

    // Level follows input once it has differed for the full count
    function automatic fault_sup_pkg::filt_t filt(input fault_sup_pkg::filt_t cur,
                                                  input logic in, input int idx);
        fault_sup_pkg::filt_t r;
        r = cur;
        if (in == cur.lvl) begin
            r.cnt = '0;
        end else if (cur.cnt + 12'h001 >= lim(idx, in)) begin
            r.lvl = in;
            r.cnt = '0;
        end else begin
            r.cnt = cur.cnt + 12'h001;
        end
        return r;
    endfunction : filt

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [`NSYNC-1:0] meta_ff;
    logic [`NSYNC-1:0] sync_ff;
    logic [`NSYNC-1:0] raw;

    assign raw = {general_output_two_i, output_below_pin, output_inreg_pin,
                  current_limit_detect, thermal_warn_pin, thermal_sd_pin,
                  overvoltage_pin, supply_uv_pin, en_pin};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= raw;
            sync_ff <= meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Debounce filters
    // ------------------------------------------------------------
    fault_sup_pkg::filt_t filt_ff [`NFILT];
    logic [`NFILT-1:0] lvl;
    logic [`NFILT-1:0] prev_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `NFILT; i++)
                filt_ff[i] <= '0;
        end else begin
            for (int i = 0; i < `NFILT; i++)
                filt_ff[i] <= filt(filt_ff[i], sync_ff[i], i);
        end
    end

    always_comb begin
        for (int i = 0; i < `NFILT; i++)
            lvl[i] = filt_ff[i].lvl;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            prev_ff <= '0;
        else
            prev_ff <= lvl;
    end

    logic en_lvl;
    logic uv_lvl;
    logic ov_lvl;
    logic tsd_lvl;
    logic [3:0] ilim_lvl;
    logic [3:0] pg_lvl;
    logic [3:0] below;

    assign en_lvl = lvl[`F_EN];
    assign uv_lvl = lvl[`F_UV];
    assign ov_lvl = lvl[`F_OV];
    assign tsd_lvl = lvl[`F_TSD];
    assign ilim_lvl = lvl[`F_ILIM +: `NREG];
    assign pg_lvl = lvl[`F_PG +: `NREG];
    assign below = sync_ff[`S_BELOW +: `NREG];

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    fault_sup_pkg::ctrl_t ctrl_ff;
    fault_sup_pkg::gpo_t gpo_ff;
    fault_sup_pkg::flags_t flags_ff;
    fault_sup_pkg::flags_t mask_ff;
    fault_sup_pkg::flags_t nxt_flags;
    logic swr_ff;
    logic req;
    logic wr;
    logic [31:0] wm;
    logic [31:0] wval;
    logic [31:0] rd_mux;
    logic [3:0] summary;
    logic soft_clr;
    logic reg_open;

    assign req = avs_read | avs_write;
    // host access only in standby and active
    assign reg_open = (mode == fault_sup_pkg::MODE_STANDBY) |
                      (mode == fault_sup_pkg::MODE_ACTIVE);
    assign wr = avs_write & ~avs_waitrequest & reg_open;
    assign wm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wval = avs_writedata & wm;
    assign summary = flags_ff.shrt | flags_ff.ilim;
    assign soft_clr = uv_lvl | swr_ff | (mode == fault_sup_pkg::MODE_OTP);

    always_comb begin
        rd_mux = '0;
        if (avs_address == `ADDR_CTRL)
            rd_mux = 32'(ctrl_ff);
        else if (avs_address == `ADDR_GPO)
            rd_mux = 32'(gpo_ff);
        else if (avs_address == `ADDR_FLAGS)
            rd_mux = 32'(flags_ff);
        else if (avs_address == `ADDR_MASK)
            rd_mux = 32'(mask_ff);
        else if (avs_address == `ADDR_STATUS)
            rd_mux = 32'({mode, summary, pg_lvl, ilim_lvl, lvl[`F_TW],
                          tsd_lvl, ov_lvl, reg_enable});
    end

    // One wait cycle, then the answer for one cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read & avs_waitrequest)
                avs_readdata <= reg_open ? rd_mux : 32'h0000_0000;
        end
    end

    // settings reloaded while regulators are held off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= '0;
            gpo_ff <= '0;
            mask_ff <= '0;
            swr_ff <= 1'b0;
        end else if (soft_clr) begin
            ctrl_ff <= '0;
            gpo_ff <= '0;
            mask_ff <= '0;
            swr_ff <= 1'b0;
        end else begin
            swr_ff <= wr & (avs_address == `ADDR_CTRL) & wval[`CTRL_SWR_BIT];
            if (wr & (avs_address == `ADDR_CTRL))
                ctrl_ff <= (ctrl_ff & ~wm[7:0]) | wval[7:0];
            if (wr & (avs_address == `ADDR_GPO))
                gpo_ff <= (gpo_ff & ~wm[6:0]) | wval[6:0];
            if (wr & (avs_address == `ADDR_MASK))
                mask_ff <= (mask_ff & ~wm[12:0]) | wval[12:0];
        end
    end

    // ------------------------------------------------------------
    // Short and overload check
    // ------------------------------------------------------------
    logic [16:0] sc_cnt_ff [`NREG];
    logic [3:0] start_ff;
    logic [3:0] sc_end;
    logic [3:0] sc_fault;

    always_comb begin
        for (int i = 0; i < `NREG; i++) begin
            sc_end[i] = reg_enable[i] & (sc_cnt_ff[i] == SC_CYC - 17'h0_0001);
            sc_fault[i] = sc_end[i] & below[i];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `NREG; i++)
                sc_cnt_ff[i] <= '0;
        end else begin
            for (int i = 0; i < `NREG; i++) begin
                if (!reg_enable[i] || sc_end[i])
                    sc_cnt_ff[i] <= '0;
                else if (start_ff[i] || below[i])
                    sc_cnt_ff[i] <= sc_cnt_ff[i] + 17'h0_0001;
                else
                    sc_cnt_ff[i] <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Regulator enables
    // ------------------------------------------------------------
    logic inhibit;
    logic [3:0] kill;

    // enables refused while live or flagged
    assign inhibit = ov_lvl | flags_ff.ov | tsd_lvl | flags_ff.tsd | ~reg_open;
    assign kill = {`NREG{uv_lvl | ov_lvl | tsd_lvl | swr_ff}} | sc_fault |
                  ~ctrl_ff.cmd_en;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_enable <= '0;
            start_ff <= '0;
        end else begin
            for (int i = 0; i < `NREG; i++) begin
                if (kill[i]) begin
                    reg_enable[i] <= 1'b0;
                    start_ff[i] <= 1'b0;
                // new start once the short flag is cleared
                end else if (!reg_enable[i] && !inhibit && !flags_ff.shrt[i]) begin
                    reg_enable[i] <= 1'b1;
                    start_ff[i] <= 1'b1;
                end else if (sc_end[i]) begin
                    start_ff[i] <= 1'b0;
                end
            end
        end
    end

    // discharge per enable bit, all on undervoltage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            discharge_on <= '1;
        else if (uv_lvl)
            discharge_on <= '1;
        else
            discharge_on <= ~reg_enable & ctrl_ff.dis_en;
    end

    // ------------------------------------------------------------
    // Flags and interrupt
    // ------------------------------------------------------------
    fault_sup_pkg::flags_t set;
    fault_sup_pkg::flags_t clr;

    always_comb begin
        set = '0;
        set.shrt = sc_fault;
        // current limit held for the filter window
        set.ilim = ilim_lvl & ~prev_ff[`F_ILIM +: `NREG];
        set.ov = ov_lvl & ~prev_ff[`F_OV];
        set.tsd = tsd_lvl & ~prev_ff[`F_TSD];
        set.twarn = lvl[`F_TW] & ~prev_ff[`F_TW];
        set.pg = |(~pg_lvl & prev_ff[`F_PG +: `NREG] & reg_enable);
        // reset event after shutdown or software reset
        set.rst_evt = soft_clr;
        clr = (wr && avs_address == `ADDR_FLAGS) ? wval[12:0] : '0;
        clr.ov = clr.ov & ~ov_lvl;
        clr.tsd = clr.tsd & ~tsd_lvl;
        nxt_flags = set | (flags_ff & ~clr);
        if (uv_lvl) begin
            nxt_flags = '0;
            nxt_flags.rst_evt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_ff <= '0;
            flags_ff.rst_evt <= 1'b1;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // irq low while any unmasked flag stands
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            irq_n_pin <= 1'b1;
        else
            irq_n_pin <= ~|(flags_ff & ~mask_ff);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            power_good_pin <= 1'b0;
        else
            power_good_pin <= (&(pg_lvl | ~reg_enable)) & ~flags_ff.ov & ~flags_ff.tsd;
    end

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    logic [3:0] otp_cnt_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode <= fault_sup_pkg::MODE_OTP;
            otp_cnt_ff <= '0;
        end else if (uv_lvl) begin
            mode <= fault_sup_pkg::MODE_SHUTDOWN;
            otp_cnt_ff <= '0;
        end else begin
            case (mode)
                fault_sup_pkg::MODE_SHUTDOWN: begin
                    mode <= fault_sup_pkg::MODE_OTP;
                end
                fault_sup_pkg::MODE_OTP: begin
                    otp_cnt_ff <= otp_cnt_ff + 4'h1;
                    if (otp_cnt_ff == `CYC_OTP)
                        mode <= fault_sup_pkg::MODE_STANDBY;
                end
                fault_sup_pkg::MODE_STANDBY: begin
                    if (|reg_enable)
                        mode <= fault_sup_pkg::MODE_ACTIVE;
                end
                fault_sup_pkg::MODE_ACTIVE: begin
                    if (~|reg_enable)
                        mode <= fault_sup_pkg::MODE_STANDBY;
                end
                default: begin
                    mode <= fault_sup_pkg::MODE_SHUTDOWN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // General outputs
    // ------------------------------------------------------------
    logic [1:0] lvl_eff;

    always_comb begin
        for (int k = 0; k < 2; k++) begin
            // sequenced outputs follow the delayed enable
            lvl_eff[k] = gpo_ff.seq[k] ? (gpo_ff.lvl[k] & en_lvl) : gpo_ff.lvl[k];
            if (ov_lvl || flags_ff.ov)
                lvl_eff[k] = 1'b0;
        end
    end

    // open drain only pulls low; push-pull drives except output two while used as clock input
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            general_output_one_o <= 1'b0;
            general_output_one_oe_n <= 1'b1;
            general_output_two_o <= 1'b0;
            general_output_two_oe_n <= 1'b1;
            external_sync_clock_in <= 1'b0;
        end else begin
            general_output_one_o <= gpo_ff.od[0] ? 1'b0 : lvl_eff[0];
            general_output_one_oe_n <= gpo_ff.od[0] & lvl_eff[0];
            // pin released when used as clock input
            general_output_two_o <= gpo_ff.od[1] ? 1'b0 : lvl_eff[1] & ~gpo_ff.pin_sel;
            general_output_two_oe_n <= gpo_ff.pin_sel | (gpo_ff.od[1] & lvl_eff[1]);
            external_sync_clock_in <= gpo_ff.pin_sel & sync_ff[`S_GENERAL_OUTPUT_TWO];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    short_kills_reg_a: assert property (@(posedge clk) disable iff (!nrst)
        (|sc_fault) |=> ((reg_enable & $past(sc_fault)) == 4'h0)
                        && ((flags_ff.shrt & $past(sc_fault)) == $past(sc_fault)))
        else $error("short did not disable regulator");

    sc_window_a: assert property (@(posedge clk) disable iff (!nrst)
        (reg_enable[0] && !start_ff[0] && sc_cnt_ff[0] == 17'h0_0000 && below[0])
        |=> (sc_cnt_ff[0] == 17'h0_0001) || !reg_enable[0])
        else $error("overload count not started");

    ov_stops_all_a: assert property (@(posedge clk) disable iff (!nrst)
        ov_lvl |=> reg_enable == 4'h0 ##1 !general_output_one_o && flags_ff.ov)
        else $error("overvoltage did not stop regulators");

    ov_discharge_a: assert property (@(posedge clk) disable iff (!nrst)
        (ov_lvl && !uv_lvl) ##1 !uv_lvl
        |=> discharge_on == $past(ctrl_ff.dis_en))
        else $error("discharge not per enable bit");

    ov_flag_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (ov_lvl && flags_ff.ov && !uv_lvl) |=> flags_ff.ov)
        else $error("overvoltage flag cleared while live");

    tsd_stops_a: assert property (@(posedge clk) disable iff (!nrst)
        tsd_lvl |=> reg_enable == 4'h0 ##1 mode != fault_sup_pkg::MODE_ACTIVE)
        else $error("thermal shutdown did not stop regulators");

    uv_shutdown_a: assert property (@(posedge clk) disable iff (!nrst)
        uv_lvl |=> mode == fault_sup_pkg::MODE_SHUTDOWN && reg_enable == 4'h0
                   && discharge_on == 4'hf)
        else $error("undervoltage did not shut down");

    swr_event_a: assert property (@(posedge clk) disable iff (!nrst)
        swr_ff |=> flags_ff.rst_evt ##1 !irq_n_pin)
        else $error("software reset left no event flag");

    irq_level_a: assert property (@(posedge clk) disable iff (!nrst)
        (|(flags_ff & ~mask_ff)) |=> !irq_n_pin)
        else $error("irq pin not asserted");

    bus_answer_a: assert property (@(posedge clk) disable iff (!nrst)
        (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");

endmodule : regulator_fault_supervisor

`default_nettype wire

//--- src/fault_sup_cfg.svh
// Constants of the regulator fault supervisor: times, counts, offsets, fields.
// Assumes a 100 MHz clk; included by the package and the top module.
`ifndef FAULT_SUP_CFG_SVH
`define FAULT_SUP_CFG_SVH

`define CLK_MHZ 100
`define T_EN_NS 3000
`define T_OVR_NS 1000
`define T_OVF_NS 20000
`define T_FLT_NS 20000
`define T_PG_NS 6000
`define T_SC_US 1000
`define CYC_EN 12'((`T_EN_NS * `CLK_MHZ + 999) / 1000)
`define CYC_OVR 12'((`T_OVR_NS * `CLK_MHZ + 999) / 1000)
`define CYC_OVF 12'((`T_OVF_NS * `CLK_MHZ + 999) / 1000)
`define CYC_FLT 12'((`T_FLT_NS * `CLK_MHZ + 999) / 1000)
`define CYC_PG 12'((`T_PG_NS * `CLK_MHZ + 999) / 1000)
`define CYC_NOW 12'h001
`define CYC_SC 17'(`T_SC_US * `CLK_MHZ)
`define CYC_OTP 4'hf

`define ADDR_CTRL 6'h00
`define ADDR_GPO 6'h04
`define ADDR_FLAGS 6'h08
`define ADDR_MASK 6'h0c
`define ADDR_STATUS 6'h10

`define CTRL_SWR_BIT 8
`define NREG 4
`define NFILT 13
`define F_EN 0
`define F_UV 1
`define F_OV 2
`define F_TSD 3
`define F_TW 4
`define F_ILIM 5
`define F_PG 9
`define S_BELOW 13
`define S_GENERAL_OUTPUT_TWO 17
`define NSYNC 18

`endif

//--- src/fault_sup_pkg.sv
// Types shared by the regulator fault supervisor.
// Assumes fault_sup_cfg.svh for the field widths.
`include "fault_sup_cfg.svh"

package fault_sup_pkg;

    typedef enum logic [3:0] {
        MODE_SHUTDOWN = 4'h1,
        MODE_OTP = 4'h2,
        MODE_STANDBY = 4'h4,
        MODE_ACTIVE = 4'h8
    } mode_t;

    typedef struct packed {
        logic lvl;
        logic [11:0] cnt;
    } filt_t;

    typedef struct packed {
        logic [3:0] dis_en;
        logic [3:0] cmd_en;
    } ctrl_t;

    typedef struct packed {
        logic pin_sel;
        logic [1:0] seq;
        logic [1:0] od;
        logic [1:0] lvl;
    } gpo_t;

    typedef struct packed {
        logic rst_evt;
        logic pg;
        logic twarn;
        logic tsd;
        logic ov;
        logic [3:0] ilim;
        logic [3:0] shrt;
    } flags_t;

endpackage : fault_sup_pkg

//--- bench/host_model.sv
// Host processor model: Avalon-MM master for register reads and writes.
// Assumes a slave that answers with waitrequest low for one cycle.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output logic [5:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable
);
    initial begin
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'hf;
    end
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        // Held until the slave answers; only the watchdog ends a hang
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : xfer
endmodule : host_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench: fault pins driven, registers reached via host model.
// Assumes the short window parameter is cut to 50 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "fault_sup_cfg.svh"
module testbench;
    logic clk, nrst, en, uv, ov, tsd, tw, wr_, rd_, wq, o1, e1, o2, e2, sc;
    logic [5:0] adr;
    logic [31:0] wd, rdd, q;
    logic [3:0] be, below, il, inr, ren, dis;
    logic irq, pg;
    fault_sup_pkg::mode_t mode;
    int mismatches = 0;
    int checked = 0;
    regulator_fault_supervisor #(.SC_CYC(17'd50)) dut (.clk(clk), .nrst(nrst),
        .avs_address(adr), .avs_read(rd_), .avs_write(wr_), .avs_writedata(wd),
        .avs_byteenable(be), .avs_readdata(rdd), .avs_waitrequest(wq), .en_pin(en),
        .supply_uv_pin(uv), .overvoltage_pin(ov), .thermal_sd_pin(tsd),
        .thermal_warn_pin(tw), .output_below_pin(below), .current_limit_detect(il),
        .output_inreg_pin(inr), .reg_enable(ren), .discharge_on(dis), .irq_n_pin(irq),
        .power_good_pin(pg), .mode(mode), .general_output_one_o(o1),
        .general_output_one_oe_n(e1), .general_output_two_o(o2),
        .general_output_two_oe_n(e2), .general_output_two_i(en),
        .external_sync_clock_in(sc));
    host_model host (.clk(clk), .waitrequest(wq), .readdata(rdd), .address(adr),
        .read(rd_), .write(wr_), .writedata(wd), .byteenable(be));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_sim();
        if (mismatches == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wreg(input logic [5:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wreg
    task automatic rreg(input logic [5:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0000_0000, q);
        chk("readdata", e, q);
    endtask : rreg
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    initial begin
        #500000;
        mismatches++;
        end_sim();
    end
    initial begin
        {nrst, en, uv, ov, tsd, tw} = 6'h00;
        {below, il, inr} = 12'h000;
        tick(6);
        nrst <= 1'b1;
        tick(40);
        chk("mode", 32'(fault_sup_pkg::MODE_STANDBY), 32'(mode));
        chk("irq_n", 32'h0, 32'(irq));
        rreg(`ADDR_FLAGS, 32'h0000_1000);
        wreg(`ADDR_FLAGS, 32'h0000_1000);
        rreg(6'h3c, 32'h0000_0000);
        tick(3);
        chk("irq_n", 32'h1, 32'(irq));
        wreg(`ADDR_GPO, 32'h0000_0003);
        below <= 4'h1;
        wreg(`ADDR_CTRL, 32'h0000_005f);
        tick(3);
        chk("mode", 32'(fault_sup_pkg::MODE_ACTIVE), 32'(mode));
        chk("gpo1", 32'h2, 32'({o1, e1}));
        for (int i = 0; i < 4; i++) begin
            below[i] <= 1'b1;
            tick(60);
            chk("reg_enable", 32'(4'hf & ~(4'h1 << i)), 32'(ren));
            rreg(`ADDR_FLAGS, 32'h1 << i);
            chk("irq_n", 32'h0, 32'(irq));
            below[i] <= 1'b0;
            wreg(`ADDR_FLAGS, 32'h1 << i);
            tick(3);
            chk("reg_enable", 32'hf, 32'(ren));
        end
        ov <= 1'b1;
        tick(120);
        chk("reg_enable", 32'h0, 32'(ren));
        chk("discharge", 32'h5, 32'(dis));
        chk("gpo1", 32'h0, 32'(o1));
        wreg(`ADDR_FLAGS, 32'h0000_0100);
        rreg(`ADDR_FLAGS, 32'h0000_0100);
        rreg(`ADDR_STATUS, 32'h0020_0010);
        ov <= 1'b0;
        tick(2100);
        wreg(`ADDR_FLAGS, 32'h0000_0100);
        tick(3);
        chk("reg_enable", 32'hf, 32'(ren));
        inr <= 4'hf;
        tick(590);
        chk("power_good", 32'h0, 32'(pg));
        tick(20);
        chk("power_good", 32'h1, 32'(pg));
        inr <= 4'h0;
        tick(610);
        chk("power_good", 32'h0, 32'(pg));
        rreg(`ADDR_FLAGS, 32'h0000_0800);
        wreg(`ADDR_FLAGS, 32'h0000_0800);
        tsd <= 1'b1;
        tick(2010);
        chk("reg_enable", 32'h0, 32'(ren));
        chk("mode", 32'(fault_sup_pkg::MODE_STANDBY), 32'(mode));
        wreg(`ADDR_FLAGS, 32'h0000_0200);
        rreg(`ADDR_FLAGS, 32'h0000_0200);
        rreg(`ADDR_STATUS, 32'h0020_0020);
        tsd <= 1'b0;
        tick(2100);
        wreg(`ADDR_FLAGS, 32'h0000_0200);
        wreg(`ADDR_CTRL, 32'h0000_0100);
        tick(40);
        rreg(`ADDR_FLAGS, 32'h0000_1000);
        rreg(`ADDR_CTRL, 32'h0000_0000);
        wreg(`ADDR_GPO, 32'h0000_0057);
        en <= 1'b1;
        tick(100);
        chk("gpo1", 32'h0, 32'({o1, e1}));
        chk("sync_clk", 32'h1, 32'(sc));
        tick(210);
        chk("gpo1", 32'h1, 32'({o1, e1}));
        chk("general_output_two", 32'h1, 32'({o2, e2}));
        il <= 4'h1;
        tick(1990);
        rreg(`ADDR_FLAGS, 32'h0000_1000);
        tick(20);
        rreg(`ADDR_FLAGS, 32'h0000_1010);
        wreg(`ADDR_MASK, 32'h0000_1010);
        tick(3);
        chk("irq_n", 32'h1, 32'(irq));
        uv <= 1'b1;
        tick(6);
        chk("mode", 32'(fault_sup_pkg::MODE_SHUTDOWN), 32'(mode));
        chk("discharge", 32'hf, 32'(dis));
        uv <= 1'b0;
        tick(360);
        chk("mode", 32'(fault_sup_pkg::MODE_STANDBY), 32'(mode));
        chk("irq_n", 32'h0, 32'(irq));
        end_sim();
    end
endmodule : testbench
`default_nettype wire
